/* testbench/dtm_core_model.sv */
// Purpose: Core-side model, vector acknowledge and UART tick counts
// Assumes: Acknowledges only while the bench enables it
// Notes: Answers after ACK_DLY+1 cycles of a pending request
`timescale 1ns/1ps
`default_nettype none
module dtm_core_model #(
  parameter int ACK_DLY = 3
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       ack_en_i,
  input  wire logic [1:0] timer_irq_i,
  input  wire logic [1:0] ext_irq_i,
  input  wire logic       rx_tick_i,
  input  wire logic       tx_tick_i,
  output logic      [1:0] ack_timer_o,
  output logic      [1:0] ack_ext_o,
  output logic      [7:0] rx_cnt_o,
  output logic      [7:0] tx_cnt_o
);
  int wait_q;
  // --------------------------------
  // Vectoring to pending sources
  // --------------------------------
  always_ff @(posedge clk_sys_i) begin
    ack_timer_o <= 2'h0;
    ack_ext_o   <= 2'h0;
    if (!rst_b_i || !ack_en_i) begin
      wait_q <= 0;
    end else if ((timer_irq_i | ext_irq_i) != 2'h0) begin
      wait_q <= (wait_q == ACK_DLY) ? 0 : wait_q + 1;
      if (wait_q == ACK_DLY) begin
        ack_timer_o <= timer_irq_i;
        ack_ext_o   <= ext_irq_i;
      end
    end
  end
  // UART clock pulses seen
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rx_cnt_o <= 8'h00;
      tx_cnt_o <= 8'h00;
    end else begin
      rx_cnt_o <= rx_cnt_o + {7'h00, rx_tick_i};
      tx_cnt_o <= tx_cnt_o + {7'h00, tx_tick_i};
    end
  end
endmodule : dtm_core_model
`default_nettype wire

/* testbench/dtm_timer_block_tb.sv */
// Purpose: Self-checking bench for the timer block
// Assumes: Counters preset near rollover keep runs short
// Notes: Core model acknowledges only where enabled
`timescale 1ns/1ps
`default_nettype none
module dtm_timer_block_tb;
  localparam logic [7:0] A_CTL = dtm_pkg::DTM_ADDR_TCTL;
  localparam logic [7:0] A_MOD = 8'h89;
  localparam logic [7:0] A_LO0 = 8'h8a;
  localparam logic [7:0] A_LO1 = 8'h8b;
  localparam logic [7:0] A_HI0 = 8'h8c;
  localparam logic [7:0] A_HI1 = 8'h8d;
  localparam logic [7:0] A_C3  = dtm_pkg::DTM_ADDR_T2CTL;
  localparam logic [7:0] A_M3  = 8'hc9;
  localparam logic [7:0] A_LO2 = 8'hcc;
  localparam logic [7:0] A_HI2 = 8'hcd;
  logic       clk_sys_i, rst_b_i, wr, rd, ack_en, t2_trig, t2_irq, rx_tick, tx_tick;
  logic [7:0] addr, wdata, rdata, rx_cnt, tx_cnt, ev;
  logic [1:0] cnt_pin, ext_b, ack_t, ack_e, t_irq, e_irq;
  int         n_fail, n_compared;
  logic [7:0] hi_v[3] = '{8'hff, 8'hff, 8'h80};
  logic [7:0] lo_v[3] = '{8'h1f, 8'hff, 8'hff};
  logic [7:0] e_v[3]  = '{8'h00, 8'h00, 8'h80};
  logic [7:0] lm_v[3] = '{8'h1f, 8'hff, 8'hff};
  assign ev = {3'h0, t2_irq, e_irq, t_irq};
  dtm_timer_block i_dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .cnt_pin_i(cnt_pin), .ext_irq_pin_b_i(ext_b), .t2_cnt_pin_i(1'b1),
    .t2_trig_pin_i(t2_trig), .ack_timer_i(ack_t), .ack_ext_i(ack_e), .timer_irq_o(t_irq),
    .ext_irq_o(e_irq), .t2_irq_o(t2_irq), .uart_rx_tick_o(rx_tick), .uart_tx_tick_o(tx_tick)
  );
  dtm_core_model i_core (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ack_en_i(ack_en), .timer_irq_i(t_irq),
    .ext_irq_i(e_irq), .rx_tick_i(rx_tick), .tx_tick_i(tx_tick), .ack_timer_o(ack_t),
    .ack_ext_o(ack_e), .rx_cnt_o(rx_cnt), .tx_cnt_o(tx_cnt)
  );
  // --------------------------------
  // Register port tasks
  // --------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_i);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_i);
    rd   <= 1'b0;
    #1;
    chk(rdata & m, exp);
  endtask : rd_chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : idle
  // Bounded wait for an interrupt level
  task automatic wait_ev(input int b, input logic lvl);
    int n;
    n = 0;
    while (ev[b] !== lvl && n < 300) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk({7'h0, ev[b]}, {7'h0, lvl});
  endtask : wait_ev
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial begin
    rst_b_i = 1'b0;
    {wr, rd, ack_en, addr, wdata} = '0;
    {t2_trig, cnt_pin, ext_b} = 5'h1f;
    idle(5);
    rst_b_i <= 1'b1;
    rd_chk(A_CTL, 8'hff, 8'h00);
    rd_chk(A_C3, 8'hff, 8'h00);
    wr_reg(8'h80, 8'hff);
    rd_chk(8'h80, 8'hff, 8'h00);
    wr_reg(A_M3, 8'hff);
    rd_chk(A_M3, 8'hff, 8'h03);
    wr_reg(A_M3, 8'h00);
    for (int m = 0; m < 3; m++) begin
      wr_reg(A_MOD, 8'(m));
      wr_reg(A_HI0, hi_v[m]);
      wr_reg(A_LO0, lo_v[m]);
      wr_reg(A_CTL, 8'h10);
      wait_ev(0, 1'b1);
      wr_reg(A_CTL, 8'h20);
      rd_chk(A_CTL, 8'hff, 8'h20);
      rd_chk(A_HI0, 8'hff, e_v[m]);
      rd_chk(A_LO0, lm_v[m], e_v[m]);
      wr_reg(A_CTL, 8'h00);
      rd_chk(A_CTL, 8'hff, 8'h00);
    end
    wr_reg(A_MOD, 8'h09);
    wr_reg(A_HI0, 8'hff);
    wr_reg(A_LO0, 8'hff);
    ext_b <= 2'h2;
    idle(30);
    rd_chk(A_LO0, 8'hff, 8'hff);
    wr_reg(A_CTL, 8'h10);
    idle(30);
    rd_chk(A_LO0, 8'hff, 8'hff);
    rd_chk(A_HI0, 8'hff, 8'hff);
    @(posedge clk_sys_i);
    ext_b <= 2'h3;
    wait_ev(0, 1'b1);
    wr_reg(A_CTL, 8'h00);
    wr_reg(A_MOD, 8'h05);
    wr_reg(A_HI0, 8'hff);
    wr_reg(A_LO0, 8'hff);
    wr_reg(A_CTL, 8'h10);
    idle(30);
    rd_chk(A_CTL, 8'hff, 8'h10);
    cnt_pin <= 2'h2;
    wait_ev(0, 1'b1);
    wr_reg(A_CTL, 8'h00);
    cnt_pin <= 2'h3;
    ack_en  <= 1'b1;
    wr_reg(A_MOD, 8'h10);
    wr_reg(A_HI1, 8'hff);
    wr_reg(A_LO1, 8'hff);
    wr_reg(A_CTL, 8'h40);
    wait_ev(1, 1'b1);
    wait_ev(1, 1'b0);
    rd_chk(A_CTL, 8'h80, 8'h00);
    chk(rx_cnt, 8'h01);
    chk(tx_cnt, 8'h01);
    wr_reg(A_MOD, 8'h33);
    ack_en <= 1'b0;
    wr_reg(A_HI0, 8'hff);
    wr_reg(A_LO0, 8'h00);
    wr_reg(A_LO1, 8'h5a);
    wr_reg(A_CTL, 8'h40);
    wait_ev(1, 1'b1);
    rd_chk(A_LO0, 8'hff, 8'h00);
    rd_chk(A_LO1, 8'hff, 8'h5a);
    wr_reg(A_HI1, 8'hff);
    wr_reg(A_LO1, 8'hff);
    wr_reg(A_MOD, 8'h13);
    idle(30);
    chk(rx_cnt, 8'h02);
    wr_reg(A_CTL, 8'h00);
    wr_reg(A_MOD, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr_reg(A_CTL, 8'(1 << (2 * i)));
      ext_b <= ~2'(1 << i);
      wait_ev(2 + i, 1'b1);
      wr_reg(A_CTL, 8'(1 << (2 * i)));
      idle(30);
      rd_chk(A_CTL, 8'hff, 8'(1 << (2 * i)));
      wr_reg(A_CTL, 8'h00);
      wait_ev(2 + i, 1'b1);
      @(posedge clk_sys_i);
      ext_b <= 2'h3;
      idle(30);
      wr_reg(A_CTL, 8'h00);
      rd_chk(A_CTL, 8'hff, 8'h00);
    end
    wr_reg(A_HI2, 8'hff);
    wr_reg(A_LO2, 8'hff);
    idle(30);
    rd_chk(A_LO2, 8'hff, 8'hff);
    wr_reg(A_C3, 8'h04);
    wait_ev(4, 1'b1);
    rd_chk(A_C3, 8'hff, 8'h84);
    wr_reg(A_C3, 8'h00);
    wr_reg(A_HI2, 8'h00);
    wr_reg(A_C3, 8'h0c);
    t2_trig <= 1'b0;
    wait_ev(4, 1'b1);
    rd_chk(A_C3, 8'hc0, 8'h40);
    wr_reg(A_C3, 8'h00);
    t2_trig <= 1'b1;
    idle(12);
    wr_reg(A_LO2, 8'h34);
    wr_reg(A_HI2, 8'h12);
    wr_reg(A_C3, 8'h0f);
    t2_trig <= 1'b0;
    wait_ev(4, 1'b1);
    rd_chk(dtm_pkg::DTM_ADDR_RCAPL, 8'hff, 8'h34);
    rd_chk(dtm_pkg::DTM_ADDR_RCAPH, 8'hff, 8'h12);
    rd_chk(A_LO2, 8'hff, 8'h34);
    wr_reg(A_C3, 8'h00);
    t2_trig <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr_reg(A_M3, (k == 1) ? 8'h02 : 8'h00);
      wr_reg(A_HI2, 8'hff);
      wr_reg(A_LO2, 8'hff);
      wr_reg(A_C3, (k == 1) ? 8'h04 : 8'h14);
      idle(30);
      rd_chk(A_C3, 8'hff, (k == 1) ? 8'h04 : 8'h14);
      wr_reg(A_C3, 8'h00);
    end
    chk(tx_cnt, 8'h03);
    chk(rx_cnt, 8'h02);
    print_verdict();
  end
endmodule : dtm_timer_block_tb
`default_nettype wire

/* verilog/dtm_pkg.sv */
// Purpose: Constants for the dual timer and third timer control block
// Assumes: Register port with byte addresses as printed, 8-bit data
// Notes on behaviour
// R1: Basic timer overflow flag set by hardware, cleared on vector ack or software write.
// R2: Basic timer runs only while its run bit is one.
// R3: External interrupt flag set on selected edge or level, cleared by ack or software.
// R4: Type bit selects falling edge (one) or low level (zero) trigger.
// R5: Mode 0 counts 13 bits: high byte plus low five bits of low byte.
// R6: Rollover of the active width from all ones to zero sets overflow flag.
// R7: Count enabled when run is one and gate is zero or pin high.
// R8: Setting run bit leaves the count registers unchanged.
// R9: Mode 1 cascades high and low bytes into one 16-bit counter.
// R10: Mode 2 reloads low byte from high byte on overflow, sets flag.
// R11: Second timer in mode 3 stops and holds its count.
// R12: First timer mode 3: low byte own controls, high byte machine cycles with second controls.
// R13: With first in mode 3, second starts and stops by leaving and entering mode 3. Code also needs the second run bit one.
// R14: Third timer mode chosen from run, clock selects, capture select and output enable.
// R15: Third overflow flag set on overflow, never in baud or clock-out, software clear.
// R16: Third external flag set on trigger fall when enabled, outside clock-out, software clear. Code also needs the start/stop bit one.
// R17: Clock select bits route third or second timer overflows to UART clocks.
// R18: Trigger fall causes capture or reload when enabled and not clocking UART. Code does neither in clock-out or while the timer is stopped.
// R19: Third timer runs only while its start/stop bit is one.
// R20: Counter select picks machine-cycle tick or external falling edges.
// R21: Capture/reload select ignored in baud mode, reload on overflow forced.
// R22: Mode register bit 1 clock output enable, bit 0 up/down enable, rest zero.
// R23: Timer function increments once per machine cycle of six oscillator periods.
// R24: Counter function increments on sampled one-to-zero of the count pin.
// R25: Vector acknowledge per source clears basic overflow and external flags.
package dtm_pkg;
  localparam logic [7:0] DTM_ADDR_TCTL  = 8'h88;
  localparam logic [7:0] DTM_ADDR_BASIC_TIMER_MODE_SELECT  = 8'h89;
  localparam logic [7:0] DTM_ADDR_T2CTL = 8'hc8;
  localparam logic [7:0] DTM_ADDR_THIRD_TIMER_MODE = 8'hc9;
  localparam logic [7:0] DTM_ADDR_TL0   = 8'h8a;
  localparam logic [7:0] DTM_ADDR_TL1   = 8'h8b;
  localparam logic [7:0] DTM_ADDR_TH0   = 8'h8c;
  localparam logic [7:0] DTM_ADDR_TH1   = 8'h8d;
  localparam logic [7:0] DTM_ADDR_RCAPL = 8'hca;
  localparam logic [7:0] DTM_ADDR_RCAPH = 8'hcb;
  localparam logic [7:0] DTM_ADDR_TL2   = 8'hcc;
  localparam logic [7:0] DTM_ADDR_TH2   = 8'hcd;
  localparam logic [7:0] DTM_RST_BYTE   = 8'h00;
  localparam logic [7:0] DTM_THIRD_TIMER_MODE_MASK = 8'h03;
  // Timer control bit positions
  localparam int DTM_TF1 = 7;
  localparam int DTM_TR1 = 6;
  localparam int DTM_TF0 = 5;
  localparam int DTM_TR0 = 4;
  localparam int DTM_IE1 = 3;
  localparam int DTM_IT1 = 2;
  localparam int DTM_IE0 = 1;
  localparam int DTM_IT0 = 0;
  // Third timer control and mode register bit positions
  localparam int DTM_TF2  = 7;
  localparam int DTM_THIRD_TIMER_EXTERNAL_FLAG = 6;
  localparam int DTM_RCLK = 5;
  localparam int DTM_UART_TRANSMIT_CLOCK_SELECT = 4;
  localparam int DTM_EXEN = 3;
  localparam int DTM_TR2  = 2;
  localparam int DTM_CT2  = 1;
  localparam int DTM_CPRL = 0;
  localparam int DTM_OE   = 1;
  localparam int DTM_UP_DOWN_COUNT_ENABLE = 0;
  // Mode select nibble: gate, c/t, m1, m0
  localparam int DTM_GATE = 3;
  localparam int DTM_CT   = 2;
  localparam logic [1:0] DTM_M13 = 2'h0;
  localparam logic [1:0] DTM_M16 = 2'h1;
  localparam logic [1:0] DTM_M8R = 2'h2;
  localparam logic [1:0] DTM_MSPLIT = 2'h3;
  // Machine cycle timing
  localparam int DTM_CLK_MHZ = 100;
  localparam int DTM_OSC_PER_MC = 6;
  localparam int DTM_MC_NS = 60;
  localparam int DTM_MC_CYC = (DTM_MC_NS * DTM_CLK_MHZ) / 1000;
  typedef enum logic [2:0] {
    DTM_T2_OFF, DTM_T2_RELOAD, DTM_T2_CAPTURE, DTM_T2_CLKOUT, DTM_T2_BAUD
  } dtm_t2_mode_t;
endpackage : dtm_pkg

/* verilog/dtm_sync_fall.sv */
// Purpose: Two-flop synchroniser with a sampled-fall detector
// Assumes: Sample strobe marks machine-cycle boundaries
// Notes: First flop read only by the second
`timescale 1ns/1ps
`default_nettype none
module dtm_sync_fall (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  input  wire logic sample_i,
  output logic      level_o,
  output logic      fall_o
);
  logic meta_q;
  logic samp_q;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      meta_q  <= 1'b1;
      level_o <= 1'b1;
    end else begin
      meta_q  <= pin_i;
      level_o <= meta_q;
    end
  end
  // Fall seen when one sample high and the next low
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      samp_q <= 1'b1;
      fall_o <= 1'b0;
    end else if (sample_i) begin
      samp_q <= level_o;
      fall_o <= samp_q & ~level_o;
    end else begin
      fall_o <= 1'b0;
    end
  end
endmodule : dtm_sync_fall
`default_nettype wire

/* verilog/dtm_timer_block.sv */
// Purpose: Two basic timers, external interrupt flags, third timer control
// Assumes: Register port, read data the cycle after the read strobe
// Notes: One machine cycle every six system clocks
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dtm_timer_block (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [1:0] cnt_pin_i,
  input  wire logic [1:0] ext_irq_pin_b_i,
  input  wire logic       t2_cnt_pin_i,
  input  wire logic       t2_trig_pin_i,
  input  wire logic [1:0] ack_timer_i,
  input  wire logic [1:0] ack_ext_i,
  output logic      [1:0] timer_irq_o,
  output logic      [1:0] ext_irq_o,
  output logic            t2_irq_o,
  output logic            uart_rx_tick_o,
  output logic            uart_tx_tick_o
);
  logic [7:0] tctl_q;
  logic [7:0] basic_timer_mode_select_q;
  logic [7:0] t2ctl_q;
  logic [7:0] third_timer_mode_q;
  logic [7:0] tl_q [2];
  logic [7:0] th_q [2];
  logic [7:0] rcapl_q;
  logic [7:0] rcaph_q;
  logic [15:0] t2_q;
  logic [2:0] mc_cnt_q;
  logic       mc_tick;
  logic [1:0] cnt_fall;
  logic [1:0] irq_lvl;
  logic [1:0] irq_fall;
  logic       t2c_fall;
  logic       t2x_lvl;
  logic       t2x_fall;
  logic [1:0] inc;
  logic       th0_inc;
  logic [1:0] ov;
  logic       th0_ov;
  logic       t2_ov;
  logic       t2_inc;
  logic       t2_trig_evt;
  logic       wr_tctl;
  logic       wr_t2ctl;
  dtm_pkg::dtm_t2_mode_t t2_mode;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] r, input logic w);
    wr_hit = w && (a == r);
  endfunction : wr_hit

  assign wr_tctl  = wr_hit(addr_i, dtm_pkg::DTM_ADDR_TCTL, wr_i);
  assign wr_t2ctl = wr_hit(addr_i, dtm_pkg::DTM_ADDR_T2CTL, wr_i);

  // ----------------------------------------
  // Machine cycle and input synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      mc_cnt_q <= 3'h0;
    end else if (mc_tick) begin
      mc_cnt_q <= 3'h0;
    end else begin
      mc_cnt_q <= mc_cnt_q + 3'h1;
    end
  end
  assign mc_tick = (mc_cnt_q == 3'(dtm_pkg::DTM_MC_CYC - 1)); // [R23]

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      dtm_sync_fall u_cnt (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .pin_i     (cnt_pin_i[g]),
        .sample_i  (mc_tick),
        .level_o   (),
        .fall_o    (cnt_fall[g])
      );
      dtm_sync_fall u_irq (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .pin_i     (ext_irq_pin_b_i[g]),
        .sample_i  (mc_tick),
        .level_o   (irq_lvl[g]),
        .fall_o    (irq_fall[g])
      );
    end
  endgenerate
  dtm_sync_fall u_t2c (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (t2_cnt_pin_i),
    .sample_i  (mc_tick),
    .level_o   (),
    .fall_o    (t2c_fall)
  );
  dtm_sync_fall u_t2x (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (t2_trig_pin_i),
    .sample_i  (mc_tick),
    .level_o   (t2x_lvl),
    .fall_o    (t2x_fall)
  );

  // ----------------------------------------
  // Basic timer count enables
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // Counter function pulses arrive the cycle after the sampled fall
      inc[i] = tctl_q[dtm_pkg::DTM_TR0 + 2 * i] // [R2] [R7]
               && (!basic_timer_mode_select_q[4 * i + dtm_pkg::DTM_GATE] || irq_lvl[i])
               && (basic_timer_mode_select_q[4 * i + dtm_pkg::DTM_CT] ? cnt_fall[i] : mc_tick); // [R24]
    end
    if (basic_timer_mode_select_q[5:4] == dtm_pkg::DTM_MSPLIT) begin
      inc[1] = 1'b0; // [R11] [R13]
    end
    th0_inc = tctl_q[dtm_pkg::DTM_TR1] && mc_tick; // [R12]
  end

  // ----------------------------------------
  // Basic timer counters
  // ----------------------------------------
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      logic [1:0] md;
      assign md = basic_timer_mode_select_q[4 * g + 1 -: 2];
      always_comb begin
        case (md)
          dtm_pkg::DTM_M13: ov[g] = inc[g] && (&th_q[g]) && (&tl_q[g][4:0]); // [R5] [R6]
          dtm_pkg::DTM_M16: ov[g] = inc[g] && (&th_q[g]) && (&tl_q[g]); // [R9]
          default:          ov[g] = inc[g] && (&tl_q[g]); // [R10] [R12]
        endcase
      end
      // Count registers change only on counts or writes, never on run [R8]
      always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
          tl_q[g] <= dtm_pkg::DTM_RST_BYTE;
        end else if (wr_hit(addr_i, g ? dtm_pkg::DTM_ADDR_TL1 : dtm_pkg::DTM_ADDR_TL0, wr_i)) begin
          tl_q[g] <= wdata_i;
        end else if (inc[g]) begin
          case (md)
            dtm_pkg::DTM_M13: tl_q[g] <= {tl_q[g][7:5], tl_q[g][4:0] + 5'h01}; // [R5]
            dtm_pkg::DTM_M8R: tl_q[g] <= ov[g] ? th_q[g] : tl_q[g] + 8'h01; // [R10]
            default:          tl_q[g] <= tl_q[g] + 8'h01;
          endcase
        end
      end
      always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
          th_q[g] <= dtm_pkg::DTM_RST_BYTE;
        end else if (wr_hit(addr_i, g ? dtm_pkg::DTM_ADDR_TH1 : dtm_pkg::DTM_ADDR_TH0, wr_i)) begin
          th_q[g] <= wdata_i;
        end else if (g == 0 && md == dtm_pkg::DTM_MSPLIT) begin
          if (th0_inc) begin
            th_q[g] <= th_q[g] + 8'h01; // [R12]
          end
        end else if (inc[g]) begin
          if (md == dtm_pkg::DTM_M13 && (&tl_q[g][4:0])) begin
            th_q[g] <= th_q[g] + 8'h01;
          end else if (md == dtm_pkg::DTM_M16 && (&tl_q[g])) begin
            th_q[g] <= th_q[g] + 8'h01; // [R9]
          end
        end
      end
    end
  endgenerate
  assign th0_ov = (basic_timer_mode_select_q[1:0] == dtm_pkg::DTM_MSPLIT) && th0_inc && (&th_q[0]);

  // ----------------------------------------
  // Timer control register and flags
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tctl_q <= dtm_pkg::DTM_RST_BYTE;
    end else begin
      logic [7:0] n;
      n = wr_tctl ? wdata_i : tctl_q;
      for (int i = 0; i < 2; i++) begin
        if (ack_timer_i[i]) begin
          n[dtm_pkg::DTM_TF0 + 2 * i] = 1'b0; // [R25]
        end
        if (ack_ext_i[i]) begin
          n[dtm_pkg::DTM_IE0 + 2 * i] = 1'b0; // [R25]
        end
        // Set wins over software or acknowledge clear
        if (ov[i] && !(i == 1 && basic_timer_mode_select_q[1:0] == dtm_pkg::DTM_MSPLIT)) begin
          n[dtm_pkg::DTM_TF0 + 2 * i] = 1'b1; // [R1] [R6]
        end
        if (tctl_q[dtm_pkg::DTM_IT0 + 2 * i] ? irq_fall[i] : !irq_lvl[i]) begin
          n[dtm_pkg::DTM_IE0 + 2 * i] = 1'b1; // [R3] [R4]
        end
      end
      if (th0_ov) begin
        n[dtm_pkg::DTM_TF1] = 1'b1; // [R12]
      end
      tctl_q <= n;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      basic_timer_mode_select_q <= dtm_pkg::DTM_RST_BYTE;
    end else if (wr_hit(addr_i, dtm_pkg::DTM_ADDR_BASIC_TIMER_MODE_SELECT, wr_i)) begin
      basic_timer_mode_select_q <= wdata_i;
    end
  end

  // ----------------------------------------
  // Third timer
  // ----------------------------------------
  always_comb begin
    if (!t2ctl_q[dtm_pkg::DTM_TR2]) begin
      t2_mode = dtm_pkg::DTM_T2_OFF; // [R19]
    end else if (t2ctl_q[dtm_pkg::DTM_RCLK] || t2ctl_q[dtm_pkg::DTM_UART_TRANSMIT_CLOCK_SELECT]) begin
      t2_mode = dtm_pkg::DTM_T2_BAUD; // [R14] [R21]
    end else if (t2ctl_q[dtm_pkg::DTM_CPRL]) begin
      t2_mode = dtm_pkg::DTM_T2_CAPTURE;
    end else if (third_timer_mode_q[dtm_pkg::DTM_OE]) begin
      t2_mode = dtm_pkg::DTM_T2_CLKOUT;
    end else begin
      t2_mode = dtm_pkg::DTM_T2_RELOAD;
    end
  end
  assign t2_inc = (t2_mode != dtm_pkg::DTM_T2_OFF)
                  && (t2ctl_q[dtm_pkg::DTM_CT2] ? t2c_fall : mc_tick); // [R20]
  assign t2_ov = t2_inc && (&t2_q);
  assign t2_trig_evt = t2ctl_q[dtm_pkg::DTM_EXEN] && t2x_fall; // [R18]

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      t2_q <= 16'h0000;
    end else if (wr_hit(addr_i, dtm_pkg::DTM_ADDR_TL2, wr_i)) begin
      t2_q[7:0] <= wdata_i;
    end else if (wr_hit(addr_i, dtm_pkg::DTM_ADDR_TH2, wr_i)) begin
      t2_q[15:8] <= wdata_i;
    end else if (t2_trig_evt && t2_mode == dtm_pkg::DTM_T2_RELOAD) begin
      t2_q <= {rcaph_q, rcapl_q}; // [R18]
    end else if (t2_ov && t2_mode != dtm_pkg::DTM_T2_CAPTURE) begin
      t2_q <= {rcaph_q, rcapl_q}; // [R21]
    end else if (t2_inc) begin
      t2_q <= t2_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rcapl_q <= dtm_pkg::DTM_RST_BYTE;
      rcaph_q <= dtm_pkg::DTM_RST_BYTE;
    end else if (t2_trig_evt && t2_mode == dtm_pkg::DTM_T2_CAPTURE) begin
      {rcaph_q, rcapl_q} <= t2_q; // [R18] [R21]
    end else if (wr_hit(addr_i, dtm_pkg::DTM_ADDR_RCAPL, wr_i)) begin
      rcapl_q <= wdata_i;
    end else if (wr_hit(addr_i, dtm_pkg::DTM_ADDR_RCAPH, wr_i)) begin
      rcaph_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      t2ctl_q <= dtm_pkg::DTM_RST_BYTE;
    end else begin
      logic [7:0] n;
      n = wr_t2ctl ? wdata_i : t2ctl_q;
      if (t2_ov && t2_mode != dtm_pkg::DTM_T2_BAUD && t2_mode != dtm_pkg::DTM_T2_CLKOUT) begin
        n[dtm_pkg::DTM_TF2] = 1'b1; // [R15]
      end
      if (t2_trig_evt && t2_mode != dtm_pkg::DTM_T2_CLKOUT && t2_mode != dtm_pkg::DTM_T2_OFF) begin
        n[dtm_pkg::DTM_THIRD_TIMER_EXTERNAL_FLAG] = 1'b1; // [R16]
      end
      t2ctl_q <= n;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      third_timer_mode_q <= dtm_pkg::DTM_RST_BYTE;
    end else if (wr_hit(addr_i, dtm_pkg::DTM_ADDR_THIRD_TIMER_MODE, wr_i)) begin
      third_timer_mode_q <= wdata_i & dtm_pkg::DTM_THIRD_TIMER_MODE_MASK; // [R22]
    end
  end

  // ----------------------------------------
  // Outputs and read port
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      timer_irq_o    <= 2'h0;
      ext_irq_o      <= 2'h0;
      t2_irq_o       <= 1'b0;
      uart_rx_tick_o <= 1'b0;
      uart_tx_tick_o <= 1'b0;
    end else begin
      timer_irq_o    <= {tctl_q[dtm_pkg::DTM_TF1], tctl_q[dtm_pkg::DTM_TF0]};
      ext_irq_o      <= {tctl_q[dtm_pkg::DTM_IE1], tctl_q[dtm_pkg::DTM_IE0]};
      t2_irq_o       <= t2ctl_q[dtm_pkg::DTM_TF2] | t2ctl_q[dtm_pkg::DTM_THIRD_TIMER_EXTERNAL_FLAG]; // [R16]
      uart_rx_tick_o <= t2ctl_q[dtm_pkg::DTM_RCLK] ? t2_ov : ov[1]; // [R17]
      uart_tx_tick_o <= t2ctl_q[dtm_pkg::DTM_UART_TRANSMIT_CLOCK_SELECT] ? t2_ov : ov[1]; // [R17]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        dtm_pkg::DTM_ADDR_TCTL:  rdata_o <= tctl_q;
        dtm_pkg::DTM_ADDR_BASIC_TIMER_MODE_SELECT:  rdata_o <= basic_timer_mode_select_q;
        dtm_pkg::DTM_ADDR_T2CTL: rdata_o <= t2ctl_q;
        dtm_pkg::DTM_ADDR_THIRD_TIMER_MODE: rdata_o <= third_timer_mode_q;
        dtm_pkg::DTM_ADDR_TL0:   rdata_o <= tl_q[0];
        dtm_pkg::DTM_ADDR_TL1:   rdata_o <= tl_q[1];
        dtm_pkg::DTM_ADDR_TH0:   rdata_o <= th_q[0];
        dtm_pkg::DTM_ADDR_TH1:   rdata_o <= th_q[1];
        dtm_pkg::DTM_ADDR_RCAPL: rdata_o <= rcapl_q;
        dtm_pkg::DTM_ADDR_RCAPH: rdata_o <= rcaph_q;
        dtm_pkg::DTM_ADDR_TL2:   rdata_o <= t2_q[7:0];
        dtm_pkg::DTM_ADDR_TH2:   rdata_o <= t2_q[15:8];
        default:                 rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_mc_period: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R23]
    mc_tick |=> !mc_tick [*5] ##1 mc_tick) else $error("machine cycle not six clocks");
  a_run_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R2]
    !tctl_q[dtm_pkg::DTM_TR0] && !wr_hit(addr_i, dtm_pkg::DTM_ADDR_TL0, wr_i) |=> $stable(tl_q[0]))
    else $error("first timer moved while stopped");
  a_ovf_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R1]
    ov[0] |=> tctl_q[dtm_pkg::DTM_TF0]) else $error("overflow flag not set");
  a_reload_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R10]
    ov[0] && basic_timer_mode_select_q[1:0] == dtm_pkg::DTM_M8R && !wr_i |=> tl_q[0] == $past(th_q[0]))
    else $error("low byte not reloaded");
  a_t1_held: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R11]
    basic_timer_mode_select_q[5:4] == dtm_pkg::DTM_MSPLIT && !wr_i |=> $stable(tl_q[1]))
    else $error("second timer counted in mode 3");
  a_tf2_baud: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R15]
    t2_mode == dtm_pkg::DTM_T2_BAUD && !t2ctl_q[dtm_pkg::DTM_TF2] && !wr_t2ctl |=> !t2ctl_q[dtm_pkg::DTM_TF2])
    else $error("third overflow flag set in baud mode");
  a_ext_level: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R4]
    !tctl_q[dtm_pkg::DTM_IT0] && !irq_lvl[0] |=> tctl_q[dtm_pkg::DTM_IE0])
    else $error("low level did not set flag");
  a_t2_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R19]
    !t2ctl_q[dtm_pkg::DTM_TR2] && !wr_i |=> $stable(t2_q)) else $error("third timer moved while off");
  c_ovf0: cover property (@(posedge clk_sys_i) ov[0]);
  c_th0: cover property (@(posedge clk_sys_i) th0_ov);
  c_capt: cover property (@(posedge clk_sys_i) t2_trig_evt && t2_mode == dtm_pkg::DTM_T2_CAPTURE);
endmodule : dtm_timer_block
`default_nettype wire
